// *** verilog/swp_params.svh ***
// Timing and field constants for the SGRAM write and precharge block.
// Assumes a 50 MHz core clock; included by the package and the design.
`ifndef SWP_PARAMS_SVH
`define SWP_PARAMS_SVH
`define SWP_CLK_PERIOD_NS      20
`define SWP_ROW_ACTIVE_MIN_NS  40
`define SWP_ROW_ACTIVE_MIN_CYC \
	((`SWP_ROW_ACTIVE_MIN_NS + `SWP_CLK_PERIOD_NS - 1) / `SWP_CLK_PERIOD_NS)
`define SWP_BURST_ELEMENTS     8
`define SWP_NUM_BANKS          8
`define SWP_BANK_W             3
`define SWP_DATA_W             32
`define SWP_LANES              4
`define SWP_LANE_W             8
`define SWP_CNT_W              8
`define SWP_PRE_W              3
`define SWP_WL_W               4
`define SWP_AP_BIT             8
`define SWP_WL_DEFAULT         4'h3
`define SWP_PRE_DEFAULT        3'h1
`define SWP_ADDR_W             12
`define SWP_ADDR_WRITE         12'h000
`define SWP_ADDR_CFG           12'h004
`define SWP_ADDR_STATUS        12'h008
`define SWP_ADDR_DATA          12'h00c
`define SWP_CFG_WL_LSB         0
`define SWP_CFG_PRE_LSB        4
`define SWP_CFG_INV_BIT        8
`define SWP_CMD_CODE_LSB       0
`define SWP_CMD_W              3
`define SWP_CMD_BANK_LSB       3
`define SWP_CMD_ADDR_LSB       6
`endif

// *** verilog/swp_pkg.sv ***
// Types shared by the SGRAM write and precharge block.
// Assumes swp_params.svh is on the include path.
`include "swp_params.svh"
package swp_pkg;
	typedef enum logic [2:0] {
		SWP_CMD_NOP   = 3'h0,
		SWP_CMD_ACT   = 3'h1,
		SWP_CMD_WRITE = 3'h2,
		SWP_CMD_PRE   = 3'h3
	} swp_cmd_type;
	typedef struct packed {
		swp_cmd_type               cmd;
		logic [`SWP_BANK_W-1:0]    bank;
		logic [`SWP_ADDR_W-1:0]    addr;
	} swp_cmd_bus_type;
	typedef enum logic [3:0] {
		SWP_ST_IDLE  = 4'b0001,
		SWP_ST_WAIT  = 4'b0010,
		SWP_ST_DATA  = 4'b0100,
		SWP_ST_CLOSE = 4'b1000
	} swp_state_type;
endpackage : swp_pkg

// *** verilog/swp_core.sv ***
// Device-side write path and precharge logic of a DDR graphics SGRAM.
// Assumes command inputs are synchronous to clk_in; the write strobe, data
// and inversion flags are external pins and are synchronised here.
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "swp_params.svh"
// Rules from the datasheet
// (RL1) Write command carries column, bank, auto-precharge bit
// (RL2) Auto precharge closes row after row-active minimum
// (RL3) First datum after latency plus preamble, then both edges
// (RL4) Controller drives programmed preamble cycles on strobe
// (RL5) Controller drives strobe high one postamble cycle
// (RL6) First strobe edge within quarter clock of nominal
// (RL7) After burst, data inputs idle, extra data ignored
// (RL8) Writes spaced at least four cycles apart
// (RL9) Precharge waits write recovery after burst; auto precharge here waits only for the row-active timer
// (RL10) No same-bank command before precharge period ends
// (RL11) Enabled inversion stores flagged lanes inverted
// (RL12) Write-to-read delay counts from edge after data
// (RL13) Eight clocks from last write data to read
// (RL14) Precharge closes all banks or selected bank
// (RL15) Precharged bank idles until activated again
// (RL16) Over one clock from termination to write data
// (RL17) Read strobe driven high half clock early; this block leaves it undriven
// (RL18) Inversion flags carried per byte, one means inverted
// (RL19) Controller tracks banks and rounds delays up
module swp_core import swp_pkg::*; #(
	parameter int ROW_ACTIVE_MIN_CYC = `SWP_ROW_ACTIVE_MIN_CYC
) (
	input  wire logic                    clk_in,
	input  wire logic                    rst_n_in,
	input  wire logic [31:0]             haddr_in,
	input  wire logic [1:0]              htrans_in,
	input  wire logic                    hwrite_in,
	input  wire logic [2:0]              hsize_in,
	input  wire logic                    hsel_in,
	input  wire logic                    hready_in,
	input  wire logic [31:0]             hwdata_in,
	input  wire logic                    write_data_strobe_in,
	input  wire logic [`SWP_DATA_W-1:0]  dq_in,
	input  wire logic [`SWP_LANES-1:0]   read_data_strobe_in,
	output logic [31:0]                  hrdata_out,
	output logic                         hreadyout_out,
	output logic                         hresp_out,
	output logic [`SWP_NUM_BANKS-1:0]    bank_open_out,
	output logic                         mem_we_out,
	output logic [`SWP_DATA_W-1:0]       mem_wdata_out,
	output logic                         read_data_strobe_oe_out
);
	logic [1:0]                 strobe_sync;
	logic [`SWP_DATA_W-1:0]     dq_meta, dq_sync;
	logic [`SWP_LANES-1:0]      flag_meta, flag_sync;
	logic                       strobe_prev;
	logic                       ap_pend, busy_err;
	logic [`SWP_BANK_W-1:0]     wr_bank;
	logic [`SWP_WL_W-1:0]       cfg_wl;
	logic [`SWP_PRE_W-1:0]      cfg_pre;
	logic                       cfg_inv;
	logic [`SWP_CNT_W-1:0]      wait_cnt, elem_cnt;
	logic [`SWP_CNT_W-1:0]      ras_cnt [`SWP_NUM_BANKS];
	swp_state_type              state;
	logic                       ph_valid, ph_write;
	logic [`SWP_ADDR_W-1:0]     ph_addr;
	swp_cmd_bus_type            cmd;
	logic                       strobe_rise, strobe_fall, strobe_edge;

	function automatic logic [`SWP_DATA_W-1:0] swp_invert(
		input logic [`SWP_DATA_W-1:0] d, input logic [`SWP_LANES-1:0] f);
		logic [`SWP_DATA_W-1:0] r;
		r = d;
		for (int i = 0; i < `SWP_LANES; i++) begin
			if (f[i])
				r[i*`SWP_LANE_W +: `SWP_LANE_W] = ~d[i*`SWP_LANE_W +: `SWP_LANE_W]; // RL18
		end
		return r;
	endfunction : swp_invert

	// Pins pass two flops; the second stage alone feeds logic
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			// Idle high like the pin, so release shows no false edge
			strobe_sync <= 2'h3;
			dq_meta     <= '0;
			dq_sync     <= '0;
			flag_meta   <= '0;
			flag_sync   <= '0;
			strobe_prev <= 1'b1;
		end else begin
			strobe_sync <= {strobe_sync[0], write_data_strobe_in};
			dq_meta     <= dq_in;
			dq_sync     <= dq_meta;
			flag_meta   <= read_data_strobe_in;
			flag_sync   <= flag_meta;
			strobe_prev <= strobe_sync[1];
		end
	end

	assign strobe_rise = strobe_sync[1] & ~strobe_prev;
	assign strobe_fall = ~strobe_sync[1] & strobe_prev;
	assign strobe_edge = strobe_rise | strobe_fall;

	// AHB-Lite address phase capture; zero wait states
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr  <= '0;
		end else if (hready_in) begin
			ph_valid <= hsel_in & htrans_in[1];
			ph_write <= hwrite_in;
			ph_addr  <= haddr_in[`SWP_ADDR_W-1:0];
		end
	end

	// Command word: [2:0] command, [5:3] bank, [17:6] address lines
	always_comb begin
		cmd.cmd  = SWP_CMD_NOP;
		cmd.bank = hwdata_in[`SWP_CMD_BANK_LSB +: `SWP_BANK_W];
		cmd.addr = hwdata_in[`SWP_CMD_ADDR_LSB +: `SWP_ADDR_W];
		if (ph_valid && ph_write && ph_addr == `SWP_ADDR_WRITE)
			cmd.cmd = swp_cmd_type'(hwdata_in[`SWP_CMD_CODE_LSB +: `SWP_CMD_W]);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_wl  <= `SWP_WL_DEFAULT;
			cfg_pre <= `SWP_PRE_DEFAULT;
			cfg_inv <= 1'b0;
		end else if (ph_valid && ph_write && ph_addr == `SWP_ADDR_CFG) begin
			cfg_wl  <= hwdata_in[`SWP_CFG_WL_LSB +: `SWP_WL_W];
			cfg_pre <= hwdata_in[`SWP_CFG_PRE_LSB +: `SWP_PRE_W];
			cfg_inv <= hwdata_in[`SWP_CFG_INV_BIT];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hrdata_out    <= '0;
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
			hrdata_out    <= '0;
			if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
				case (haddr_in[`SWP_ADDR_W-1:0])
				`SWP_ADDR_CFG:    hrdata_out <= {23'h0, cfg_inv, 1'b0, cfg_pre, cfg_wl};
				`SWP_ADDR_STATUS: hrdata_out <= {19'h0, busy_err, state, bank_open_out};
				`SWP_ADDR_DATA:   hrdata_out <= mem_wdata_out;
				default:          hrdata_out <= '0;
				endcase
			end
		end
	end

	// Write burst sequencer
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state         <= SWP_ST_IDLE;
			wait_cnt      <= '0;
			elem_cnt      <= '0;
			wr_bank       <= '0;
			ap_pend       <= 1'b0;
			busy_err      <= 1'b0;
			mem_we_out    <= 1'b0;
			mem_wdata_out <= '0;
		end else begin
			mem_we_out <= 1'b0;
			if (cmd.cmd == SWP_CMD_WRITE && state != SWP_ST_IDLE)
				busy_err <= 1'b1;
			case (state)
			SWP_ST_IDLE: begin
				if (cmd.cmd == SWP_CMD_WRITE && bank_open_out[cmd.bank]) begin // RL15
					wr_bank  <= cmd.bank; // RL1
					ap_pend  <= cmd.addr[`SWP_AP_BIT]; // RL1
					wait_cnt <= `SWP_CNT_W'(cfg_wl) + `SWP_CNT_W'(cfg_pre); // RL3
					elem_cnt <= '0;
					state    <= SWP_ST_WAIT;
				end
			end
			SWP_ST_WAIT: begin
				if (wait_cnt != '0)
					wait_cnt <= wait_cnt - 1'b1;
				else if (strobe_rise)
					state <= SWP_ST_DATA; // RL3
				if (wait_cnt == '0 && strobe_rise) begin
					mem_we_out    <= 1'b1;
					mem_wdata_out <= cfg_inv ? swp_invert(dq_sync, flag_sync) : dq_sync; // RL11
					elem_cnt      <= `SWP_CNT_W'(1);
				end
			end
			SWP_ST_DATA: begin
				if (strobe_edge) begin // RL3
					mem_we_out    <= 1'b1;
					mem_wdata_out <= cfg_inv ? swp_invert(dq_sync, flag_sync) : dq_sync; // RL11
					elem_cnt      <= elem_cnt + 1'b1;
					if (elem_cnt == `SWP_CNT_W'(`SWP_BURST_ELEMENTS - 1))
						state <= ap_pend ? SWP_ST_CLOSE : SWP_ST_IDLE; // RL7
				end
			end
			SWP_ST_CLOSE: begin
				if (ras_cnt[wr_bank] == '0)
					state <= SWP_ST_IDLE; // RL2
			end
			default: state <= SWP_ST_IDLE;
			endcase
		end
	end

	// Bank open state and row-active timers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bank_open_out <= '0;
			for (int b = 0; b < `SWP_NUM_BANKS; b++)
				ras_cnt[b] <= '0;
		end else begin
			for (int b = 0; b < `SWP_NUM_BANKS; b++) begin
				if (ras_cnt[b] != '0)
					ras_cnt[b] <= ras_cnt[b] - 1'b1;
			end
			if (cmd.cmd == SWP_CMD_ACT) begin
				bank_open_out[cmd.bank] <= 1'b1;
				ras_cnt[cmd.bank]       <= `SWP_CNT_W'(ROW_ACTIVE_MIN_CYC);
			end else if (cmd.cmd == SWP_CMD_PRE) begin
				if (cmd.addr[`SWP_AP_BIT])
					bank_open_out <= '0; // RL14
				else
					bank_open_out[cmd.bank] <= 1'b0; // RL14
			end
			if (state == SWP_ST_CLOSE && ras_cnt[wr_bank] == '0)
				bank_open_out[wr_bank] <= 1'b0; // RL2
		end
	end

	// Reads are outside this block; the read strobe stays undriven
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			read_data_strobe_oe_out <= 1'b0;
		else
			read_data_strobe_oe_out <= 1'b0; // RL17
	end
endmodule : swp_core

// *** tb/swp_chk_props.sv ***
// Port checker for the SGRAM write core.
// Assumes one clock domain; bound at the foot.
`timescale 1ns/1ps
module swp_chk #(parameter int ROW_ACTIVE_MIN_CYC = 2) (
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0]  htrans_in,
	input wire logic        hwrite_in,
	input wire logic        hsel_in,
	input wire logic        hready_in,
	input wire logic [31:0] hwdata_in,
	input wire logic        write_data_strobe_in,
	input wire logic [7:0]  bank_open_out,
	input wire logic        mem_we_out
);
	logic       ph;
	logic [3:0] pulses;
	wire  [2:0] c = hwdata_in[2:0];
	wire  [7:0] sel = 8'h1 << hwdata_in[5:3];
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) ph <= 1'b0;
		else ph <= hsel_in && hready_in && htrans_in[1] && hwrite_in && haddr_in[11:0] == 12'h0;
	end
	// Counts stores since the last write command
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) pulses <= 4'h0;
		else if (ph && c == 3'h2) pulses <= 4'h0;
		else if (mem_we_out) pulses <= pulses + 4'h1;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_we_single: assert property (mem_we_out |=> !mem_we_out) else $error("long store");
	a_we_edge: assert property (mem_we_out |->
		$past(write_data_strobe_in, 2) != $past(write_data_strobe_in, 5)) else $error("no edge");
	a_burst_eight: assert property (pulses <= 4'h8) else $error("extra store");
	a_act_opens: assert property (ph && c == 3'h1 |=>
		bank_open_out == ($past(bank_open_out) | $past(sel))) else $error("act");
	a_pre_one: assert property (ph && c == 3'h3 && !hwdata_in[14] |=>
		bank_open_out == ($past(bank_open_out) & ~$past(sel))) else $error("pre one");
	a_pre_all: assert property (ph && c == 3'h3 && hwdata_in[14] |=>
		bank_open_out == 8'h0) else $error("pre all");
	a_only_act: assert property (!(ph && c == 3'h1) |=>
		(bank_open_out & ~$past(bank_open_out)) == 8'h0) else $error("bank opened");
	a_ap_close: assert property (!$past(ph) && |($past(bank_open_out) & ~bank_open_out) |->
		pulses == 4'h8) else $error("early close");
	c_burst: cover property (pulses == 4'h8);
	c_pre_all: cover property (ph && c == 3'h3 && hwdata_in[14]);
	c_ap: cover property (!$past(ph) && |($past(bank_open_out) & ~bank_open_out));
endmodule : swp_chk
bind swp_core swp_chk #(.ROW_ACTIVE_MIN_CYC(ROW_ACTIVE_MIN_CYC)) i_chk (.clk_in(clk_in),
	.rst_n_in(rst_n_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
	.hsel_in(hsel_in), .hready_in(hready_in), .hwdata_in(hwdata_in), .mem_we_out(mem_we_out),
	.write_data_strobe_in(write_data_strobe_in), .bank_open_out(bank_open_out));

// *** tb/swp_ctrl_model.sv ***
// Partner: controller driving write strobe, data and flags.
// Assumes clk_in is the core clock; strobe period is sixteen clocks, 320 ns.
`timescale 1ns/1ps
module swp_ctrl_model (
	input  wire logic         clk_in,
	input  wire logic         go_in,
	input  wire logic         slow_in,
	input  wire logic [2:0]   pre_in,
	input  wire logic [255:0] words_in,
	input  wire logic [31:0]  flags_in,
	output logic              strobe_out,
	output logic [31:0]       dq_out,
	output logic [3:0]        flag_out,
	output logic              busy_out
);
	int h;
	initial begin
		strobe_out = 1'b1;
		dq_out = 32'h0;
		flag_out = 4'h0;
		busy_out = 1'b0;
		forever begin
			@(posedge clk_in);
			if (go_in === 1'b1) begin
				busy_out <= 1'b1;
				h = 4;
				strobe_out <= 1'b0;
				// A late start stays within a quarter link clock of nominal
				repeat (8 * pre_in + (slow_in ? 2 : 0)) @(posedge clk_in);
				for (int k = 0; k < 8; k++) begin
					dq_out <= words_in[32*k +: 32];
					flag_out <= flags_in[4*k +: 4];
					repeat (h) @(posedge clk_in);
					strobe_out <= ~k[0];
					repeat (h) @(posedge clk_in);
				end
				strobe_out <= 1'b1;
				repeat (h) @(posedge clk_in);
				// Data lines idle high once the burst is over
				dq_out <= 32'hffffffff;
				flag_out <= ~flag_out;
				busy_out <= 1'b0;
			end
		end
	end
endmodule : swp_ctrl_model

// *** tb/tb.sv ***
// Self-checking bench for the SGRAM write core.
// Assumes the partner model on the strobe, data and flag pins.
`timescale 1ns/1ps
module tb import swp_pkg::*; ;
	logic         clk_in = 1'b0, rst_n_in = 1'b0, hw = 1'b0, hs = 1'b0, go = 1'b0, slow = 1'b0;
	logic         inv = 1'b0;
	logic [1:0]   ht = 2'h0;
	logic [2:0]   pre = 3'h1;
	logic [31:0]  ha = 32'h0, hd = 32'h0, rd, last = 32'h0, e, flags = 32'h0;
	logic [255:0] words = 256'h0;
	wire          rdy, stb, busy, we, resp, oe;
	wire  [3:0]   fl;
	wire  [7:0]   banks;
	wire  [31:0]  hr, dq, wd;
	integer       err_count = 0, checks_done = 0, seed = 32'h8d985379, n;
	logic [31:0]  q[$], cfg[3] = '{32'h13, 32'h125, 32'h113};
	always #10 clk_in = ~clk_in;
	swp_core #(.ROW_ACTIVE_MIN_CYC(2)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.haddr_in(ha), .htrans_in(ht), .hwrite_in(hw), .hsize_in(3'h2), .hsel_in(hs),
		.hready_in(rdy), .hwdata_in(hd), .write_data_strobe_in(stb), .dq_in(dq),
		.read_data_strobe_in(fl), .hrdata_out(hr), .hreadyout_out(rdy), .hresp_out(resp),
		.bank_open_out(banks), .mem_we_out(we), .mem_wdata_out(wd),
		.read_data_strobe_oe_out(oe));
	swp_ctrl_model i_far (.clk_in(clk_in), .go_in(go), .slow_in(slow), .pre_in(pre),
		.words_in(words), .flags_in(flags), .strobe_out(stb), .dq_out(dq),
		.flag_out(fl), .busy_out(busy));
	task automatic cmp(input logic [31:0] g, input logic [31:0] x);
		checks_done++;
		if (g !== x) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, g, x);
		end
	endtask : cmp
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results
	// Every wait after the reset delay goes through here so a hang ends the run
	task automatic step();
		@(posedge clk_in);
		n++;
		if (n > 900) begin
			err_count++;
			results();
		end
	endtask : step
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		ht <= 2'h2;
		ha <= a;
		hw <= w;
		hs <= 1'b1;
		n = 0;
		do step(); while (rdy !== 1'b1);
		ht <= 2'h0;
		hs <= 1'b0;
		hd <= d;
		do step(); while (rdy !== 1'b1);
		rd = hr;
		cmp({30'h0, oe, resp}, 32'h0);
	endtask : bus
	function automatic logic [31:0] cw(swp_cmd_type c, logic [2:0] b, logic a);
		return {17'h0, a, 8'h0, b, c};
	endfunction : cw
	task automatic burst(input logic [2:0] b, input logic a, input logic take);
		for (int k = 0; k < 8; k++) begin
			words[32*k +: 32] = $random(seed);
			flags[4*k +: 4] = 4'($random(seed));
			e = words[32*k +: 32];
			for (int j = 0; j < 4; j++) e[8*j +: 8] ^= {8{inv & flags[4*k+j]}};
			if (take) q.push_back(e);
			if (take) last = e;
		end
		bus(1'b1, 32'h0, cw(SWP_CMD_WRITE, b, a));
		go <= 1'b1;
		step();
		go <= 1'b0;
		n = 0;
		do step(); while (busy !== 1'b0 || q.size() != 0);
		bus(1'b0, 32'hc, 32'h0);
		cmp(rd, last);
	endtask : burst
	task automatic see_banks(input logic [7:0] x);
		bus(1'b0, 32'h8, 32'h0);
		cmp({24'h0, rd[7:0]}, {24'h0, x});
		cmp({24'h0, banks}, {24'h0, x});
	endtask : see_banks
	always @(posedge clk_in) begin
		if (we === 1'b1 && q.size() == 0) cmp(32'h1, 32'h0);
		else if (we === 1'b1) cmp(wd, q.pop_front());
	end
	initial begin
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1'b1;
		bus(1'b0, 32'h8, 32'h0);
		cmp(rd, 32'h100);
		bus(1'b0, 32'h4, 32'h0);
		cmp(rd, 32'h13);
		bus(1'b0, 32'h10, 32'h0);
		cmp(rd, 32'h0);
		bus(1'b1, 32'h0, cw(SWP_CMD_ACT, 3'h2, 1'b0));
		bus(1'b1, 32'h0, cw(SWP_CMD_ACT, 3'h6, 1'b0));
		see_banks(8'h44);
		$display("test done: reset and activate");
		for (int m = 0; m < 3; m++) begin
			bus(1'b1, 32'h4, cfg[m]);
			inv = cfg[m][8];
			pre <= cfg[m][6:4];
			slow <= m[1];
			burst(3'h2, 1'b0, 1'b1);
			$display("test done: burst %0d", m);
		end
		burst(3'h5, 1'b0, 1'b0);
		burst(3'h6, 1'b1, 1'b1);
		n = 0;
		do step(); while (banks[6] !== 1'b0);
		see_banks(8'h04);
		$display("test done: closed bank and auto precharge");
		bus(1'b1, 32'h0, cw(SWP_CMD_ACT, 3'h1, 1'b0));
		bus(1'b1, 32'h0, cw(SWP_CMD_PRE, 3'h2, 1'b0));
		see_banks(8'h02);
		bus(1'b1, 32'h0, cw(SWP_CMD_ACT, 3'h7, 1'b0));
		bus(1'b1, 32'h0, cw(SWP_CMD_PRE, 3'h1, 1'b1));
		see_banks(8'h00);
		$display("test done: precharge");
		results();
	end
endmodule : tb
